//--- azd_pkg.sv
// Purpose: shared constants and types for the audio zero-detect flag block
// Assumes: one 125 MHz clock; word clock arrives as a pin
// Notes: control bits come in as plain inputs, no register bus
package azd_pkg;
  localparam int SAMPLE_W = 24;
  localparam int ZERO_RUN_LEN = 1024;
  localparam int RUN_CNT_W = 11;
  localparam logic POLARITY_INVERT_RST = 1'b0;
  localparam logic COMBINE_SELECT_RST = 1'b0;
  localparam logic ZERO_MUTE_EN_RST = 1'b0;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } azd_sample_pair_t;

  typedef struct packed {
    logic flag_polarity_invert;
    logic flag_combine_select;
    logic zero_mute_enable;
  } azd_ctrl_t;
endpackage

//--- azd_chan_det.sv
// Purpose: zero-run counter for one audio channel
// Assumes: sample_tick_i is a one-cycle pulse, once per word period
// Notes: one instance per channel, nothing is shared between them
`timescale 1ns/1ns
module azd_chan_det #(
  parameter int SAMPLE_W = azd_pkg::SAMPLE_W,
  parameter int RUN_LEN = azd_pkg::ZERO_RUN_LEN
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sample_tick_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic zero_det_o
);
  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] RUN_MAX = CW'(RUN_LEN);

  initial begin
    if (RUN_LEN < 1) $error("RUN_LEN must be at least 1");
  end

  logic [CW-1:0] run_r;

  // count saturates so the condition holds for as long as zeros persist
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_r <= '0;
    end else if (sample_tick_i) begin
      if (sample_i != '0) begin
        run_r <= '0; // [RULE8]
      end else if (run_r != RUN_MAX) begin
        run_r <= run_r + CW'(1); // [RULE2]
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zero_det_o <= 1'b0;
    end else begin
      zero_det_o <= (run_r == RUN_MAX); // [RULE2]
    end
  end
endmodule // azd_chan_det

//--- azd_zero_flags.sv
// Purpose: per-channel zero detection and zero-flag pin drive
// Assumes: samples valid while sample_valid_i pulses; word clock is a pin
// Notes: one word period is one full cycle of the word-select clock
`timescale 1ns/1ns
// What this block does
// RULE1: left and right channels each run their own zero-detect counter.
// RULE2: a channel is zero-detected after 1024 consecutive zero samples.
// RULE3: a zero-detected channel drives its flag to logic 1 by default.
// RULE4: the polarity-invert bit flips flag levels and resets to 0.
// RULE5: the combine-select bit makes one shared flag and resets to 0.
// RULE6: zero-data muting is disabled from reset so zeros still pass.
// RULE7: in combined mode the shared flag uses the right flag pin only.
// RULE8: any nonzero sample restarts the count and clears the condition.
module azd_zero_flags #(
  parameter int SAMPLE_W = azd_pkg::SAMPLE_W,
  parameter int RUN_LEN = azd_pkg::ZERO_RUN_LEN
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic word_select_clock_i,
  input wire logic sample_valid_i,
  input wire azd_pkg::azd_sample_pair_t samples_i,
  input wire azd_pkg::azd_ctrl_t ctrl_i,
  output logic left_zero_flag_out_o,
  output logic right_zero_flag_out_o,
  output logic zero_mute_active_o
);
  // ************************************************************
  // word clock sync and period tick
  // ************************************************************
  logic [2:0] wsc_sync_r;
  logic wsc_state_r;
  logic word_tick_r;
  azd_pkg::azd_sample_pair_t held_r;

  initial begin
    if (SAMPLE_W < 1) $error("SAMPLE_W must be at least 1");
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wsc_sync_r <= 3'h0;
    end else begin
      wsc_sync_r <= {wsc_sync_r[1:0], word_select_clock_i};
    end
  end

  // a level change counts once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wsc_state_r <= 1'b0;
      word_tick_r <= 1'b0;
    end else begin
      word_tick_r <= 1'b0;
      if (wsc_sync_r[1] == wsc_sync_r[2] && wsc_sync_r[2] != wsc_state_r) begin
        wsc_state_r <= wsc_sync_r[2];
        word_tick_r <= wsc_sync_r[2];
      end
    end
  end

  // latest sample of each channel, captured on every cycle that sample_valid_i is high
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held_r <= '0;
    end else if (sample_valid_i) begin
      held_r <= samples_i;
    end
  end

  // ************************************************************
  // per-channel detectors
  // ************************************************************
  logic [1:0] det;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      azd_chan_det #(
        .SAMPLE_W(SAMPLE_W),
        .RUN_LEN(RUN_LEN)
      ) u_det (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .sample_tick_i(word_tick_r),
        .sample_i(g == 0 ? held_r.left : held_r.right),
        .zero_det_o(det[g])
      ); // [RULE1]
    end
  endgenerate

  // ************************************************************
  // flag pins
  // ************************************************************
  // shared flag means both channels zero; unassigned pin sits inactive
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_zero_flag_out_o <= azd_pkg::POLARITY_INVERT_RST;
      right_zero_flag_out_o <= azd_pkg::POLARITY_INVERT_RST;
    end else if (ctrl_i.flag_combine_select) begin
      left_zero_flag_out_o <= ctrl_i.flag_polarity_invert; // [RULE7]
      right_zero_flag_out_o <= (det[0] & det[1])
        ^ ctrl_i.flag_polarity_invert; // [RULE5] [RULE4]
    end else begin
      left_zero_flag_out_o <= det[0]
        ^ ctrl_i.flag_polarity_invert; // [RULE3] [RULE4]
      right_zero_flag_out_o <= det[1]
        ^ ctrl_i.flag_polarity_invert; // [RULE3] [RULE4]
    end
  end

  // muting only if enabled; reset default leaves data path untouched
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zero_mute_active_o <= azd_pkg::ZERO_MUTE_EN_RST; // [RULE6]
    end else begin
      zero_mute_active_o <= ctrl_i.zero_mute_enable & det[0] & det[1];
    end
  end
endmodule // azd_zero_flags

//--- azd_src_model.sv
// Purpose: audio source model for the zero-flag block
// Assumes: word clock 6 cycles high, 6 low
// Notes: samples move at the word fall, clear of the block's tick
`timescale 1ns/1ns
module azd_src_model (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire azd_pkg::azd_sample_pair_t next_i,
  output logic word_o,
  output logic valid_o,
  output azd_pkg::azd_sample_pair_t samples_o
);
  logic [3:0] ph_r;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_r <= 4'h0;
      word_o <= 1'b0;
      valid_o <= 1'b0;
      samples_o <= '0;
    end else begin
      ph_r <= (ph_r == 4'hB) ? 4'h0 : ph_r + 4'h1;
      word_o <= ph_r < 4'h6;
      valid_o <= 1'b1;
      if (ph_r == 4'h6) samples_o <= next_i;
    end
  end
endmodule // azd_src_model

//--- azd_monitor.sv
// Purpose: port checker for the zero-flag block
// Assumes: samples stay steady around each word rise
// Notes: counts word rises per channel, saturating at 15
`timescale 1ns/1ns
module azd_monitor #(parameter int RUN_LEN = 8) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic word_select_clock_i,
  input wire azd_pkg::azd_sample_pair_t samples_i,
  input wire azd_pkg::azd_ctrl_t ctrl_i,
  input wire logic left_zero_flag_out_o,
  input wire logic right_zero_flag_out_o,
  input wire logic zero_mute_active_o
);
  logic [1:0][3:0] zr_r, nz_r;
  logic wd_r;
  wire [1:0] z = {samples_i.left == '0, samples_i.right == '0};
  wire cb = ctrl_i.flag_combine_select;
  wire iv = ctrl_i.flag_polarity_invert;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zr_r <= '0;
      nz_r <= '0;
      wd_r <= 1'b0;
    end else begin
      wd_r <= word_select_clock_i;
      for (int c = 0; c < 2; c++) begin
        if (word_select_clock_i && !wd_r) begin
          zr_r[c] <= z[c] ? zr_r[c] + 4'(zr_r[c] != 4'hF) : 4'h0;
          nz_r[c] <= z[c] ? 4'h0 : nz_r[c] + 4'(nz_r[c] != 4'hF);
        end
      end
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_left_detect: assert property ($stable(ctrl_i) && zr_r[1] > RUN_LEN && !cb
    |-> left_zero_flag_out_o == !iv) else $error("left flag late");
  a_right_detect: assert property ($stable(ctrl_i) && zr_r[0] > RUN_LEN && !cb
    |-> right_zero_flag_out_o == !iv) else $error("right flag late");
  a_shared_set: assert property ($stable(ctrl_i) && cb && zr_r[0] > RUN_LEN &&
    zr_r[1] > RUN_LEN |-> right_zero_flag_out_o == !iv)
    else $error("shared flag late");
  a_left_clear: assert property ($stable(ctrl_i) && nz_r[1] > 1 && !cb
    |-> left_zero_flag_out_o == iv) else $error("left flag stuck");
  a_right_clear: assert property ($stable(ctrl_i) && nz_r[0] > 1 && !cb
    |-> right_zero_flag_out_o == iv) else $error("right flag stuck");
  a_shared_clear: assert property ($stable(ctrl_i) && cb &&
    (nz_r[0] > 1 || nz_r[1] > 1)
    |-> right_zero_flag_out_o == iv) else $error("shared flag stuck");
  a_combine_left: assert property ($stable(ctrl_i) && cb
    |-> left_zero_flag_out_o == iv) else $error("left pin driven");
  a_mute_off: assert property (!ctrl_i.zero_mute_enable
    |-> !zero_mute_active_o) else $error("mute without enable");
endmodule // azd_monitor
bind azd_zero_flags azd_monitor #(.RUN_LEN(RUN_LEN)) azd_monitor_i (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .samples_i(samples_i),
  .word_select_clock_i(word_select_clock_i), .ctrl_i(ctrl_i),
  .left_zero_flag_out_o(left_zero_flag_out_o),
  .right_zero_flag_out_o(right_zero_flag_out_o),
  .zero_mute_active_o(zero_mute_active_o));

//--- tb_top.sv
// Purpose: self-checking bench for the zero-flag block
// Assumes: run length shortened to 8 word periods of 12 cycles
// Notes: flags are read 1 ns after the last clock edge of each wait
`timescale 1ns/1ns
module tb_top;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  azd_pkg::azd_sample_pair_t nxt = '0;
  azd_pkg::azd_sample_pair_t smp;
  azd_pkg::azd_ctrl_t ctrl = '0;
  logic wsc, vld, lf, rf, mt;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  azd_src_model azd_src_model_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .next_i(nxt), .word_o(wsc), .valid_o(vld), .samples_o(smp));
  azd_zero_flags #(.RUN_LEN(8)) azd_zero_flags_i (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .word_select_clock_i(wsc), .sample_valid_i(vld),
    .samples_i(smp), .ctrl_i(ctrl), .left_zero_flag_out_o(lf),
    .right_zero_flag_out_o(rf), .zero_mute_active_o(mt));
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wp(input int n);
    repeat (n * 12) @(posedge ref_clk_i);
    #1;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    wp(7);
    chk(lf, 1'b0);
    wp(3);
    chk(lf, 1'b1);
    chk(mt, 1'b0);
    nxt.right = 24'h000001;
    wp(3);
    chk(lf, 1'b1);
    chk(rf, 1'b0);
    ctrl.flag_polarity_invert = 1'b1;
    wp(1);
    chk(lf, 1'b0);
    ctrl = '0;
    ctrl.flag_combine_select = 1'b1;
    ctrl.zero_mute_enable = 1'b1;
    nxt = '0;
    wp(10);
    chk(lf, 1'b0);
    chk(rf, 1'b1);
    chk(mt, 1'b1);
    nxt.left = 24'h000005;
    wp(3);
    chk(rf, 1'b0);
    chk(mt, 1'b0);
    print_verdict();
  end
endmodule // tb_top
